// ---- rtl/power_mode_controller.sv ----
// Operating mode controller: run, slow, wait, stop and halt sequencing.
`timescale 1ns/1ps
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter logic [STAB_W-1:0] STAB_CYCLES = STAB_W'(OSC_STAB_CYCLES)
)
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // CPU requests
    input  wire logic                  slow_sel,
    input  wire logic [DIV_W-1:0]      slow_ratio,
    input  wire logic                  wait_for_interrupt_instr,
    input  wire logic                  stop_seq_done,
    input  wire logic                  halt_instr,
    input  wire logic                  pll_select_req,
    // Interrupt controller
    input  wire logic                  irq_ack,
    // Wake sources
    input  wire logic [WAKE_LINES-1:0] wake_line,
    input  wire logic                  nmi,
    // Oscillator and watchdog
    input  wire logic                  osc_running,
    input  wire logic                  wdg_enable,
    // Clock enables, PLL selection and CPU hold
    output logic                       cpu_clk_en,
    output logic                       periph_clk_en,
    output logic                       osc_enable,
    output logic                       pll_selected,
    output logic                       cpu_hold,
    // Watchdog and status
    output logic [WDG_W-1:0]           wdg_count,
    output logic [4:0]                 mode
);
    typedef struct packed {
        pm_mode_t          mode;
        exit_state_t       ex;
        logic              cpu_en;
        logic              per_en;
        logic              osc_en;
        logic              pll;
        logic              hold;
        logic [WDG_W-1:0]  wdg;
    } pmc_state_t;

    pmc_state_t state_q;
    pmc_state_t state_d;
    logic       slow_tick;
    logic       stab_done;
    logic       stab_start;
    logic       base_tick;
    logic       wake_any;

    // Divided enable for the slow rate.
    pmc_clk_div u_div (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (state_q.mode == MODE_SLOW || state_q.mode == MODE_WAIT),
        .ratio   (slow_ratio),
        .tick    (slow_tick)
    );

    pmc_stab_counter #(.CYCLES(STAB_CYCLES)) u_stab (
        .clk         (clk),
        .reset_n     (reset_n),
        .start       (stab_start),
        .osc_running (osc_running),
        .done        (stab_done)
    );

    assign wake_any   = (|wake_line) || nmi;
    assign stab_start = (state_q.mode == MODE_STOP) && (state_q.ex == EX_IDLE) && wake_any;

    always_comb begin
        state_d = state_q;
        base_tick = slow_sel ? slow_tick : 1'b1;
        if (pll_select_req) begin
            state_d.pll = 1'b1;
        end
        case (state_q.mode)
            MODE_RUN, MODE_SLOW: begin
                state_d.mode = slow_sel ? MODE_SLOW : MODE_RUN;
                if (halt_instr && !wdg_enable) begin
                    state_d.mode = MODE_HALT;
                end else if (stop_seq_done && !nmi) begin
                    state_d.mode = MODE_STOP;
                    state_d.osc_en = 1'b0;
                    state_d.pll = 1'b0;
                end else if (wait_for_interrupt_instr) begin
                    state_d.mode = MODE_WAIT;
                end
            end
            MODE_WAIT: begin
                if (irq_ack) begin
                    state_d.mode = slow_sel ? MODE_SLOW : MODE_RUN;
                end
            end
            MODE_STOP: begin
                state_d.pll = 1'b0;
                case (state_q.ex)
                    EX_IDLE: begin
                        if (wake_any) begin
                            state_d.ex = EX_COUNT;
                            state_d.osc_en = 1'b1;
                        end
                    end
                    EX_COUNT: begin
                        if (stab_done) begin
                            state_d.ex = EX_IDLE;
                            state_d.mode = slow_sel ? MODE_SLOW : MODE_RUN;
                        end
                    end
                    default: begin
                        state_d.ex = EX_IDLE;
                    end
                endcase
            end
            MODE_HALT: begin
                state_d.mode = MODE_HALT;
            end
            default: begin
                state_d.mode = MODE_RUN;
            end
        endcase
        // Enables follow the mode being entered so they line up with it.
        case (state_d.mode)
            MODE_RUN, MODE_SLOW: begin
                state_d.cpu_en = base_tick;
                state_d.per_en = base_tick;
            end
            MODE_WAIT: begin
                state_d.cpu_en = 1'b0;
                state_d.per_en = base_tick;
            end
            default: begin
                state_d.cpu_en = 1'b0;
                state_d.per_en = 1'b0;
            end
        endcase
        state_d.hold = (state_d.mode != MODE_RUN) && (state_d.mode != MODE_SLOW);
        if ((state_q.mode != MODE_STOP) && (state_q.mode != MODE_HALT) && wdg_enable
            && state_d.per_en) begin
            state_d.wdg = state_q.wdg - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q.mode   <= MODE_RUN;
            state_q.ex     <= EX_IDLE;
            state_q.cpu_en <= 1'b1;
            state_q.per_en <= 1'b1;
            state_q.osc_en <= 1'b1;
            state_q.pll    <= 1'b1;
            state_q.hold   <= 1'b0;
            state_q.wdg    <= WDG_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign cpu_clk_en    = state_q.cpu_en;
    assign periph_clk_en = state_q.per_en;
    assign osc_enable    = state_q.osc_en;
    assign pll_selected  = state_q.pll;
    assign cpu_hold      = state_q.hold;
    assign wdg_count     = state_q.wdg;
    assign mode          = state_q.mode;

    property p_onehot;
        @(posedge clk) disable iff (!reset_n) $onehot(mode);
    endproperty
    a_onehot: assert property (p_onehot) else $error("mode not one-hot");

    property p_halt_sticky;
        // The synchronous reset is the only way out, so a cycle that samples it low is excused.
        @(posedge clk) disable iff (!reset_n)
            reset_n && mode == MODE_HALT |=> mode == MODE_HALT;
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt left");

    property p_wdg_frozen;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_STOP && $past(mode) == MODE_STOP |-> $stable(wdg_count);
    endproperty
    a_wdg_frozen: assert property (p_wdg_frozen) else $error("watchdog moved in stop");

    property p_stop_entry;
        @(posedge clk) disable iff (!reset_n)
            $rose(mode == MODE_STOP) |-> !$past(nmi) && $past(stop_seq_done);
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("bad stop entry");

    property p_wait_gate;
        @(posedge clk) disable iff (!reset_n) mode == MODE_WAIT |-> !cpu_clk_en;
    endproperty
    a_wait_gate: assert property (p_wait_gate) else $error("cpu clock in wait");

    property p_stop_quiet;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_STOP |-> !cpu_clk_en && !periph_clk_en && !pll_selected;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("clock in stop");

    property p_stop_exit;
        @(posedge clk) disable iff (!reset_n)
            $fell(mode == MODE_STOP) |-> $past(stab_done);
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("early stop exit");

    property p_wait_exit;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_WAIT && irq_ack |=> mode == MODE_RUN || mode == MODE_SLOW;
    endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("wait not left on ack");

    property p_halt_entry;
        @(posedge clk) disable iff (!reset_n)
            $rose(mode == MODE_HALT) |-> $past(halt_instr) && !$past(wdg_enable);
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("bad halt entry");

    property p_run_full;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_RUN |-> cpu_clk_en && periph_clk_en;
    endproperty
    a_run_full: assert property (p_run_full) else $error("run not at full rate");

    property p_slow_gap;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_SLOW && cpu_clk_en && $past(slow_ratio) != DIV_ZERO
            |=> !cpu_clk_en || mode == MODE_RUN;
    endproperty
    a_slow_gap: assert property (p_slow_gap) else $error("slow rate not divided");

    property p_wait_holds;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_WAIT && !irq_ack |=> mode == MODE_WAIT && cpu_hold;
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("wait left without ack");

    property p_stop_nmi_high;
        @(posedge clk) disable iff (!reset_n)
            mode != MODE_STOP && nmi |=> mode != MODE_STOP;
    endproperty
    a_stop_nmi_high: assert property (p_stop_nmi_high) else $error("stop with nmi high");

    property p_wake_start;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_STOP && state_q.ex == EX_IDLE && (|wake_line || nmi) |=> osc_enable;
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("wake not taken");

    property p_exit_resume;
        @(posedge clk) disable iff (!reset_n)
            $fell(mode == MODE_STOP)
            |-> (mode == MODE_RUN || mode == MODE_SLOW) && $stable(wdg_count);
    endproperty
    a_exit_resume: assert property (p_exit_resume) else $error("stop exit lost state");

    property p_wdg_counts;
        @(posedge clk) disable iff (!reset_n)
            $past(reset_n) && $past(wdg_enable) && mode == MODE_RUN && $past(mode) == MODE_RUN
            |-> wdg_count == $past(wdg_count) - 16'h0001;
    endproperty
    a_wdg_counts: assert property (p_wdg_counts) else $error("watchdog not counting");

    property p_stab_hold;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_STOP && !osc_running && !stab_done |=> mode == MODE_STOP;
    endproperty
    a_stab_hold: assert property (p_stab_hold) else $error("exit before oscillation");

    property p_osc_off;
        @(posedge clk) disable iff (!reset_n)
            $rose(mode == MODE_STOP) |-> !osc_enable;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator on in stop");

    property p_exit_no_pll;
        @(posedge clk) disable iff (!reset_n)
            $fell(mode == MODE_STOP) |-> !pll_selected && osc_enable;
    endproperty
    a_exit_no_pll: assert property (p_exit_no_pll) else $error("pll kept after stop");

    property p_halt_quiet;
        @(posedge clk) disable iff (!reset_n)
            mode == MODE_HALT |-> !cpu_clk_en && !periph_clk_en && cpu_hold;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("clock in halt");
endmodule

// ---- rtl/pmc_pkg.sv ----
// Shared constants and types of the power mode controller.
package pmc_pkg;
    localparam int unsigned CLK_HZ          = 10000000;
    localparam int unsigned OSC_STAB_US     = 5000;
    localparam int unsigned OSC_STAB_CYCLES = (OSC_STAB_US * (CLK_HZ / 1000000));
    localparam int unsigned WAKE_LINES      = 16;
    localparam int unsigned WDG_W           = 16;
    localparam int unsigned STAB_W          = 16;
    localparam int unsigned DIV_W           = 8;
    localparam logic [WDG_W-1:0]  WDG_RESET = 16'hffff;
    localparam logic [DIV_W-1:0]  DIV_ZERO  = 8'h00;
    localparam logic [STAB_W-1:0] STAB_ZERO = 16'h0000;

    typedef enum logic [4:0] {
        MODE_RUN  = 5'h01,
        MODE_SLOW = 5'h02,
        MODE_WAIT = 5'h04,
        MODE_STOP = 5'h08,
        MODE_HALT = 5'h10
    } pm_mode_t;

    typedef enum logic [2:0] {
        EX_IDLE  = 3'h1,
        EX_OSC   = 3'h2,
        EX_COUNT = 3'h4
    } exit_state_t;
endpackage

// ---- rtl/pmc_clk_div.sv ----
// Programmable clock enable divider for the slow clock rate.
`timescale 1ns/1ps
module pmc_clk_div
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] ratio,
    // Output
    output logic                  tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } div_state_t;

    div_state_t state_q;
    div_state_t state_d;

    always_comb begin
        state_d      = state_q;
        state_d.tick = 1'b0;
        if (!run) begin
            state_d.cnt = DIV_ZERO;
        end else if (state_q.cnt >= ratio) begin
            state_d.cnt  = DIV_ZERO;
            state_d.tick = 1'b1;
        end else begin
            state_d.cnt = state_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign tick = state_q.tick;
endmodule

// ---- rtl/pmc_stab_counter.sv ----
// Oscillator stabilisation counter started by the first oscillation.
`timescale 1ns/1ps
module pmc_stab_counter
    import pmc_pkg::*;
#(
    parameter logic [STAB_W-1:0] CYCLES = STAB_W'(OSC_STAB_CYCLES)
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Control
    input  wire logic start,
    input  wire logic osc_running,
    // Status
    output logic      done
);
    typedef struct packed {
        logic [STAB_W-1:0] cnt;
        logic              armed;
        logic              done;
    } stab_state_t;

    stab_state_t state_q;
    stab_state_t state_d;

    always_comb begin
        state_d      = state_q;
        state_d.done = 1'b0;
        if (start) begin
            state_d.armed = 1'b1;
            state_d.cnt   = STAB_ZERO;
        end else if (state_q.armed && osc_running) begin
            if (state_q.cnt >= CYCLES - 16'h0001) begin
                state_d.armed = 1'b0;
                state_d.done  = 1'b1;
            end else begin
                state_d.cnt = state_q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign done = state_q.done;
endmodule

// ---- sim/pmc_partner.sv ----
// Behavioural oscillator and interrupt controller facing the power mode controller.
`timescale 1ns/1ps
module pmc_partner #(
    parameter int START_CYCLES = 6
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // From the controller and the bench
    input  wire logic osc_enable,
    input  wire logic irq_req,
    // To the controller
    output logic      osc_running,
    output logic      irq_ack
);
    int start_cnt_q;

    // A restarted oscillator needs a start-up phase before it is seen to oscillate.
    always_ff @(posedge clk) begin
        if (!reset_n || !osc_enable) begin
            start_cnt_q <= 0;
            osc_running <= 1'b0;
        end else if (start_cnt_q < START_CYCLES) begin
            start_cnt_q <= start_cnt_q + 1;
        end else begin
            osc_running <= 1'b1;
        end
    end

    // Each pending request is acknowledged for a single cycle.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= irq_req && !irq_ack;
        end
    end
endmodule

// ---- sim/power_mode_controller_test.sv ----
// Self-checking testbench of the power mode controller.
`timescale 1ns/1ps
module power_mode_controller_test
    import pmc_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, slow_sel = 1'b0, wait_instr = 1'b0, stop_seq_done = 1'b0;
    logic halt_instr = 1'b0, pll_select_req = 1'b0, nmi = 1'b0, wdg_enable = 1'b1;
    logic irq_req = 1'b0, irq_ack, osc_running, cpu_clk_en, periph_clk_en, osc_enable;
    logic pll_selected, cpu_hold;
    logic [DIV_W-1:0]      slow_ratio = 8'h03;
    logic [WAKE_LINES-1:0] wake_line = 16'h0000;
    logic [WDG_W-1:0]      wdg_count;
    logic [4:0]            mode;
    int mismatches = 0, num_checks = 0, cycles = 0;

    power_mode_controller #(.STAB_CYCLES(16'h0008)) u_dut (
        .clk(clk), .reset_n(reset_n), .slow_sel(slow_sel), .slow_ratio(slow_ratio),
        .wait_for_interrupt_instr(wait_instr), .stop_seq_done(stop_seq_done),
        .halt_instr(halt_instr), .pll_select_req(pll_select_req), .irq_ack(irq_ack),
        .wake_line(wake_line), .nmi(nmi), .osc_running(osc_running),
        .wdg_enable(wdg_enable), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .osc_enable(osc_enable), .pll_selected(pll_selected), .cpu_hold(cpu_hold),
        .wdg_count(wdg_count), .mode(mode));

    pmc_partner #(.START_CYCLES(6)) u_partner (
        .clk(clk), .reset_n(reset_n), .osc_enable(osc_enable), .irq_req(irq_req),
        .osc_running(osc_running), .irq_ack(irq_ack));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    always @(negedge clk) begin
        if (reset_n) begin
            check({15'h0000, mode inside {MODE_RUN, MODE_SLOW, MODE_WAIT, MODE_STOP,
                MODE_HALT}}, 16'h0001, "mode not one-hot");
        end
    end

    task automatic rates_and_wait();
        int n;
        check({11'h000, mode}, {11'h000, MODE_RUN}, "reset mode");
        // Ten edges in RUN since the release, each one a watchdog decrement.
        check(wdg_count, WDG_RESET - 16'h000a, "watchdog counting in run");
        @(posedge clk) wait_instr <= 1'b1;
        @(posedge clk) wait_instr <= 1'b0;
        #1;
        check({11'h000, mode}, {11'h000, MODE_WAIT}, "wait entry");
        check({14'h0000, cpu_clk_en, periph_clk_en}, 16'h0001, "wait enables");
        tick(3);
        check({15'h0000, cpu_hold}, 16'h0001, "wait hold");
        @(posedge clk) irq_req <= 1'b1;
        @(posedge clk) irq_req <= 1'b0;
        tick(2);
        check({11'h000, mode}, {11'h000, MODE_RUN}, "wait exit");
        @(posedge clk) slow_sel <= 1'b1;
        tick(2);
        check({11'h000, mode}, {11'h000, MODE_SLOW}, "slow entry");
        n = 0;
        for (int i = 0; i < 16; i++) begin
            tick(1);
            n += int'(cpu_clk_en);
        end
        check(16'(n), 16'h0004, "slow tick count");
        @(posedge clk) slow_sel <= 1'b0;
        tick(2);
        n = 0;
        for (int i = 0; i < 16; i++) begin
            tick(1);
            n += int'(cpu_clk_en && periph_clk_en);
        end
        check(16'(n), 16'h0010, "run full rate");
    endtask

    // Source 16 stands for the non-maskable pin, the others for single wake lines.
    task automatic stop_and_wake(input int src);
        logic [WDG_W-1:0] frozen;
        int n;
        @(posedge clk) stop_seq_done <= 1'b1;
        @(posedge clk) stop_seq_done <= 1'b0;
        #1;
        check({11'h000, mode}, {11'h000, MODE_STOP}, "stop entry");
        check({12'h000, cpu_clk_en, periph_clk_en, osc_enable, pll_selected}, 16'h0000,
            "stop enables");
        frozen = wdg_count;
        tick(5);
        check(wdg_count, frozen, "watchdog frozen");
        @(posedge clk) begin
            if (src < 16) wake_line <= 16'h0001 << src;
            else nmi <= 1'b1;
        end
        @(posedge clk) begin
            wake_line <= 16'h0000;
            nmi <= 1'b0;
        end
        n = 1;
        // A second wake while the oscillator settles must not restart the count.
        while (mode === MODE_STOP && n < 60) begin
            @(posedge clk) wake_line <= (n == 10) ? 16'h8000 : 16'h0000;
            #1;
            n++;
        end
        check({15'h0000, n >= 16 && n <= 18}, 16'h0001, "stabilisation delay");
        check({11'h000, mode}, {11'h000, MODE_RUN}, "stop exit");
        check({14'h0000, cpu_hold, pll_selected}, 16'h0000, "exit without pll");
        tick(3);
        check({15'h0000, wdg_count !== frozen}, 16'h0001, "watchdog resumed");
        @(posedge clk) pll_select_req <= 1'b1;
        @(posedge clk) pll_select_req <= 1'b0;
        tick(2);
        check({15'h0000, pll_selected}, 16'h0001, "pll reselected");
    endtask

    task automatic stop_refused_and_halt();
        @(posedge clk) begin
            nmi <= 1'b1;
            stop_seq_done <= 1'b1;
            halt_instr <= 1'b1;
        end
        @(posedge clk) begin
            stop_seq_done <= 1'b0;
            halt_instr <= 1'b0;
            nmi <= 1'b0;
        end
        tick(2);
        check({11'h000, mode}, {11'h000, MODE_RUN}, "stop and halt refused");
        @(posedge clk) wdg_enable <= 1'b0;
        @(posedge clk) halt_instr <= 1'b1;
        @(posedge clk) halt_instr <= 1'b0;
        #1;
        check({11'h000, mode}, {11'h000, MODE_HALT}, "halt entry");
        check({14'h0000, cpu_clk_en, periph_clk_en}, 16'h0000, "halt clocks");
        @(posedge clk) begin
            wake_line <= 16'hffff;
            nmi <= 1'b1;
            irq_req <= 1'b1;
        end
        tick(6);
        check({11'h000, mode}, {11'h000, MODE_HALT}, "halt held");
        @(posedge clk) begin
            wake_line <= 16'h0000;
            nmi <= 1'b0;
            irq_req <= 1'b0;
            reset_n <= 1'b0;
        end
        @(posedge clk) reset_n <= 1'b1;
        tick(1);
        check({11'h000, mode}, {11'h000, MODE_RUN}, "reset leaves halt");
    endtask

    initial begin
        repeat (19) @(posedge clk);
        #1;
        check({11'h000, mode}, {11'h000, MODE_RUN}, "mode in reset");
        check(wdg_count, WDG_RESET, "watchdog in reset");
        @(posedge clk) reset_n <= 1'b1;
        tick(10);
        rates_and_wait();
        for (int s = 0; s <= 16; s++) begin
            stop_and_wake(s);
        end
        stop_refused_and_halt();
        report_and_stop();
    end
endmodule
